// >>> verilog/pfs_regs.svh
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define PFS_CMD_STATUS_BYTE 8'h78
`define PFS_CMD_SUMMARY_WORD 8'h79
`define PFS_CMD_VOUT 8'h7A
`define PFS_CMD_IOUT 8'h7B
`define PFS_CMD_INPUT 8'h7C
`define PFS_CMD_TEMP 8'h7D
`define PFS_CMD_CML 8'h7E
`define PFS_CMD_MAKER 8'h80
`define PFS_CMD_PADS 8'hE5
`define PFS_CMD_COMMON 8'hEF
// ----------------------------------------
// Supported bits per status byte, alert and log bits, mask reset values and reserved bits
// ----------------------------------------
`define PFS_VOUT_SUP 8'hFE
`define PFS_IOUT_SUP 8'hA0
`define PFS_INPUT_SUP 8'hAA
`define PFS_INPUT_ALERT 8'h80
`define PFS_TEMP_SUP 8'hD0
`define PFS_CML_SUP 8'hFB
`define PFS_MAKER_SUP 8'hFF
`define PFS_MAKER_LOG_BIT 3
`define PFS_MAKER_MASK_RST 8'h11
`define PFS_MASK_RST 8'h00
`define PFS_PADS_RSVD 16'h3000
`define PFS_COMMON_RSVD 8'h04
`endif

// >>> verilog/pfs_pkg.sv
package pfs_pkg;
	typedef enum logic [2:0] {
		PFS_SEL_VOUT = 3'h0,
		PFS_SEL_IOUT = 3'h1,
		PFS_SEL_INPUT = 3'h2,
		PFS_SEL_TEMP = 3'h3,
		PFS_SEL_CML = 3'h4,
		PFS_SEL_MAKER = 3'h5
	} pfs_sel_t;
endpackage

// >>> verilog/pfs_fault_status_bank.sv
`timescale 1ns/1ps
`include "pfs_regs.svh"
module pfs_fault_status_bank #(
	parameter int CHANNELS = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [CHANNELS-1:0] vEvt0,
	input wire logic [CHANNELS*8-1:0] voutEvt,
	input wire logic [CHANNELS*8-1:0] ioutEvt,
	input wire logic [7:0] inputEvt,
	input wire logic [CHANNELS*8-1:0] tempEvt,
	input wire logic [7:0] cmlEvt,
	input wire logic [7:0] makerEvt,
	input wire logic [CHANNELS-1:0] gpPulledLowEvt,
	input wire logic [CHANNELS-1:0] powerGood,
	input wire logic [7:0] statusByteIn,
	input wire logic page,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [7:0] cmdData,
	input wire logic clearAllFaults,
	input wire logic faultLogClear,
	input wire logic maskWrite,
	input wire logic [2:0] maskSel,
	input wire logic [7:0] maskData,
	input wire logic cmdRead,
	input wire logic [15:0] padInputs,
	input wire logic [7:0] commonInputs,
	output logic [15:0] readData,
	output logic readValid,
	output logic alertOut_n,
	output logic alertOe
);
	// ----------------------------------------
	// Status storage
	// ----------------------------------------
	logic [7:0] voutStat [CHANNELS];
	logic [7:0] ioutStat [CHANNELS];
	logic [7:0] tempStat [CHANNELS];
	logic [7:0] inputStat;
	logic [7:0] cmlStat;
	logic [7:0] makerShared;
	logic [CHANNELS-1:0] gpLow;
	logic [7:0] maskReg [6];
	logic [CHANNELS-1:0] chAlert;
	logic chSel;
	logic wr;
	assign chSel = page;
	assign wr = cmdWrite;

	// Hazard: a write-one clear in the same cycle as a new event loses to the event
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic selCh;
			assign selCh = (chSel == ch[0]);
			always_ff @(posedge clk) begin
				if (rst) begin
					voutStat[ch] <= 8'h00;
				end else if (clearAllFaults) begin
					voutStat[ch] <= voutEvt[ch*8 +: 8] & `PFS_VOUT_SUP;
				end else begin
					voutStat[ch] <= ((voutStat[ch] & ~((wr && selCh && cmdCode == `PFS_CMD_VOUT) ? cmdData : 8'h00))
						| voutEvt[ch*8 +: 8]) & `PFS_VOUT_SUP;
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					ioutStat[ch] <= 8'h00;
				end else if (clearAllFaults) begin
					ioutStat[ch] <= ioutEvt[ch*8 +: 8] & `PFS_IOUT_SUP;
				end else begin
					ioutStat[ch] <= ((ioutStat[ch] & ~((wr && selCh && cmdCode == `PFS_CMD_IOUT) ? cmdData : 8'h00))
						| ioutEvt[ch*8 +: 8]) & `PFS_IOUT_SUP;
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					tempStat[ch] <= 8'h00;
				end else if (clearAllFaults) begin
					tempStat[ch] <= tempEvt[ch*8 +: 8] & `PFS_TEMP_SUP;
				end else begin
					tempStat[ch] <= ((tempStat[ch] & ~((wr && selCh && cmdCode == `PFS_CMD_TEMP) ? cmdData : 8'h00))
						| tempEvt[ch*8 +: 8]) & `PFS_TEMP_SUP;
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					gpLow[ch] <= 1'b0;
				end else if (gpPulledLowEvt[ch]) begin
					gpLow[ch] <= 1'b1;
				end else if (clearAllFaults || (wr && selCh && cmdCode == `PFS_CMD_MAKER && cmdData[0])) begin
					gpLow[ch] <= 1'b0;
				end
			end
			assign chAlert[ch] = |(voutStat[ch] & ~maskReg[pfs_pkg::PFS_SEL_VOUT])
				| |(ioutStat[ch] & ~maskReg[pfs_pkg::PFS_SEL_IOUT])
				| |(tempStat[ch] & ~maskReg[pfs_pkg::PFS_SEL_TEMP])
				| (gpLow[ch] & ~maskReg[pfs_pkg::PFS_SEL_MAKER][0]);
		end
	endgenerate

	// ----------------------------------------
	// Shared status bytes
	// ----------------------------------------
	// input bits and bit-7 clear
	always_ff @(posedge clk) begin
		if (rst) begin
			inputStat <= 8'h00;
		end else if (clearAllFaults) begin
			inputStat <= inputEvt & `PFS_INPUT_SUP;
		end else begin
			inputStat <= ((inputStat & ~((wr && cmdCode == `PFS_CMD_INPUT) ? (cmdData & `PFS_INPUT_ALERT) : 8'h00))
				| inputEvt) & `PFS_INPUT_SUP;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmlStat <= 8'h00;
		end else if (clearAllFaults) begin
			cmlStat <= cmlEvt & `PFS_CML_SUP;
		end else begin
			cmlStat <= ((cmlStat & ~((wr && cmdCode == `PFS_CMD_CML) ? cmdData : 8'h00)) | cmlEvt) & `PFS_CML_SUP;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			makerShared <= 8'h00;
		end else begin
			for (int b = 1; b < 8; b++) begin
				if (makerEvt[b]) begin
					makerShared[b] <= 1'b1;
				end else if (b == `PFS_MAKER_LOG_BIT) begin
					if (faultLogClear) begin
						makerShared[b] <= 1'b0;
					end
				end else if (clearAllFaults || (wr && cmdCode == `PFS_CMD_MAKER && cmdData[b])) begin
					makerShared[b] <= 1'b0;
				end
			end
			makerShared[0] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int m = 0; m < 6; m++) begin
				maskReg[m] <= (m == 5) ? `PFS_MAKER_MASK_RST : `PFS_MASK_RST;
			end
		end else if (maskWrite && maskSel <= 3'h5) begin
			maskReg[maskSel] <= maskData;
		end
	end

	// ----------------------------------------
	// Summary and read mux
	// ----------------------------------------
	logic [7:0] makerView;
	logic [15:0] summary;
	logic [7:0] commonView;
	assign makerView = {makerShared[7:1], gpLow[chSel]};
	assign summary = {|voutStat[chSel], |ioutStat[chSel], |inputStat, |makerView,
		~powerGood[chSel], 3'h0, statusByteIn};

	// common byte, alert bit from own drive
	assign commonView = {~alertOe, commonInputs[6:0] & 7'(~`PFS_COMMON_RSVD)};

	always_ff @(posedge clk) begin
		if (rst) begin
			readData <= 16'h0000;
			readValid <= 1'b0;
		end else begin
			readValid <= cmdRead;
			if (cmdRead) begin
				unique case (cmdCode)
					`PFS_CMD_STATUS_BYTE: readData <= {8'h00, statusByteIn};
					`PFS_CMD_SUMMARY_WORD: readData <= summary;
					`PFS_CMD_VOUT: readData <= {8'h00, voutStat[chSel]};
					`PFS_CMD_IOUT: readData <= {8'h00, ioutStat[chSel]};
					`PFS_CMD_INPUT: readData <= {8'h00, inputStat};
					`PFS_CMD_TEMP: readData <= {8'h00, tempStat[chSel]};
					`PFS_CMD_CML: readData <= {8'h00, cmlStat};
					`PFS_CMD_MAKER: readData <= {8'h00, makerView};
					`PFS_CMD_PADS: readData <= padInputs & ~`PFS_PADS_RSVD;
					`PFS_CMD_COMMON: readData <= {8'h00, commonView};
					default: readData <= 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Alert drive
	// ----------------------------------------
	// open-drain active-low alert
	always_ff @(posedge clk) begin
		if (rst || clearAllFaults) begin
			alertOe <= 1'b0;
		end else begin
			alertOe <= (|chAlert) | |(inputStat & `PFS_INPUT_ALERT & ~maskReg[pfs_pkg::PFS_SEL_INPUT])
				| |(cmlStat & ~maskReg[pfs_pkg::PFS_SEL_CML])
				| |(makerShared & 8'hFE & ~maskReg[pfs_pkg::PFS_SEL_MAKER]);
		end
	end
	assign alertOut_n = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_vout_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && !chSel && cmdCode == `PFS_CMD_VOUT && cmdData[7] && !voutEvt[7] && !clearAllFaults)
		|=> !voutStat[0][7]) else $error("vout bit not cleared");
	a_vout_bit0: assert property (@(posedge clk) disable iff (rst) !voutStat[0][0])
		else $error("vout bit 0 set");
	a_iout_zero: assert property (@(posedge clk) disable iff (rst) (ioutStat[0] & 8'h5F) == 8'h00)
		else $error("iout unsupported bit set");
	a_input_alert_only7: assert property (@(posedge clk) disable iff (rst)
		(inputStat[5] && !inputStat[7] && cmlStat == 8'h00 && makerShared == 8'h00 && chAlert == '0)
		|=> !alertOe || $past(inputEvt[7])) else $error("input alert from non-7 bit");
	a_log_hold: assert property (@(posedge clk) disable iff (rst)
		(makerShared[3] && !faultLogClear) |=> makerShared[3]) else $error("fault log bit lost");
	a_clear_all: assert property (@(posedge clk) disable iff (rst)
		clearAllFaults |=> !alertOe && cmlStat == (($past(cmlEvt)) & `PFS_CML_SUP) ) else $error("clear all failed");
	a_summary_pg: assert property (@(posedge clk) disable iff (rst)
		summary[11] == !powerGood[chSel]) else $error("power-good bit wrong");
	a_summary_zero: assert property (@(posedge clk) disable iff (rst) summary[10:8] == 3'h0)
		else $error("unsupported summary bits set");
	a_maker_summary: assert property (@(posedge clk) disable iff (rst)
		(makerView != 8'h00) |-> summary[12]) else $error("maker summary missing");
	a_mask_default: assert property (@(posedge clk) $fell(rst) |-> maskReg[5] == `PFS_MAKER_MASK_RST)
		else $error("maker mask default wrong");
	a_cml_set_wins: assert property (@(posedge clk) disable iff (rst)
		(cmlEvt[7] && !clearAllFaults) |=> cmlStat[7]) else $error("cml event lost");

	// ----------------------------------------
	// Read and alert sequences
	// ----------------------------------------
	sequence s_any_read;
		cmdRead;
	endsequence
	sequence s_answer;
		readValid;
	endsequence
	sequence s_read_of(logic [7:0] code);
		cmdRead && cmdCode == code;
	endsequence

	a_summary_low: assert property (@(posedge clk) disable iff (rst)
		summary[7:0] == statusByteIn)
		else $error("summary low byte differs");
	a_summary_vout: assert property (@(posedge clk) disable iff (rst)
		summary[15] == (voutStat[chSel] != 8'h00))
		else $error("summary vout bit wrong");
	a_summary_iout: assert property (@(posedge clk) disable iff (rst)
		summary[14] == (ioutStat[chSel] != 8'h00))
		else $error("summary iout bit wrong");
	a_summary_input: assert property (@(posedge clk) disable iff (rst)
		summary[13] == (inputStat != 8'h00))
		else $error("summary input bit wrong");
	a_vout1_bit0: assert property (@(posedge clk) disable iff (rst)
		!voutStat[1][0])
		else $error("vout channel 1 bit 0 set");
	a_iout1_zero: assert property (@(posedge clk) disable iff (rst)
		(ioutStat[1] & 8'h5F) == 8'h00)
		else $error("iout channel 1 unsupported bit set");
	a_temp_zero: assert property (@(posedge clk) disable iff (rst)
		((tempStat[0] | tempStat[1]) & 8'h2F) == 8'h00)
		else $error("temperature unsupported bit set");
	a_cml_bit2: assert property (@(posedge clk) disable iff (rst)
		!cmlStat[2])
		else $error("cml bit 2 set");
	a_input_zero: assert property (@(posedge clk) disable iff (rst)
		(inputStat & 8'h55) == 8'h00)
		else $error("input unsupported bit set");
	a_gp_low_set: assert property (@(posedge clk) disable iff (rst)
		gpPulledLowEvt[0] |=> gpLow[0])
		else $error("pin pulled low not flagged");
	a_maker_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && cmdCode == `PFS_CMD_MAKER && cmdData[7] && !makerEvt[7]) |=> !makerShared[7])
		else $error("maker bit not cleared");
	a_log_clear: assert property (@(posedge clk) disable iff (rst)
		(faultLogClear && !makerEvt[3]) |=> !makerShared[3])
		else $error("fault log bit not cleared");
	a_input_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && cmdCode == `PFS_CMD_INPUT && cmdData[7] && !inputEvt[7] && !clearAllFaults) |=> !inputStat[7])
		else $error("input bit 7 not cleared");
	a_iout_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && !chSel && cmdCode == `PFS_CMD_IOUT && cmdData[7] && !ioutEvt[7] && !clearAllFaults) |=> !ioutStat[0][7])
		else $error("iout bit not cleared");
	a_temp_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && !chSel && cmdCode == `PFS_CMD_TEMP && cmdData[6] && !tempEvt[6] && !clearAllFaults) |=> !tempStat[0][6])
		else $error("temperature bit not cleared");
	a_cml_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && cmdCode == `PFS_CMD_CML && cmdData[6] && !cmlEvt[6] && !clearAllFaults) |=> !cmlStat[6])
		else $error("cml bit not cleared");
	a_read_answer: assert property (@(posedge clk) disable iff (rst)
		s_any_read |=> s_answer)
		else $error("read not answered");
	a_pads_upper: assert property (@(posedge clk) disable iff (rst)
		s_read_of(`PFS_CMD_PADS) |=> readData[15:14] == $past(padInputs[15:14]) && readData[13:12] == 2'h0
		&& readData[11:8] == $past(padInputs[11:8]))
		else $error("pad word upper bits wrong");
	a_pads_lower: assert property (@(posedge clk) disable iff (rst)
		s_read_of(`PFS_CMD_PADS) |=> readData[7:0] == $past(padInputs[7:0]))
		else $error("pad word pin bits wrong");
	a_common_byte: assert property (@(posedge clk) disable iff (rst)
		s_read_of(`PFS_CMD_COMMON) |=> readData[7] == !$past(alertOe) && readData[2] == 1'b0)
		else $error("common byte wrong");
	a_summary_read: assert property (@(posedge clk) disable iff (rst)
		s_read_of(`PFS_CMD_SUMMARY_WORD) |=> readData[10:8] == 3'h0)
		else $error("summary read unsupported bits set");
	a_alert_release: assert property (@(posedge clk) disable iff (rst)
		(chAlert == '0 && inputStat == 8'h00 && cmlStat == 8'h00 && makerShared == 8'h00) |=> !alertOe)
		else $error("alert held with no source");
	a_alert_raise: assert property (@(posedge clk) disable iff (rst)
		(cmlStat[7] && !maskReg[pfs_pkg::PFS_SEL_CML][7] && !clearAllFaults) |=> alertOe)
		else $error("alert not raised");
	a_clear_vout: assert property (@(posedge clk) disable iff (rst)
		clearAllFaults |=> voutStat[0] == ($past(voutEvt[7:0]) & `PFS_VOUT_SUP))
		else $error("clear all lost present fault");
endmodule

// >>> dv/pfs_host_model.sv
`timescale 1ns/1ps
module pfs_host_model (
	input wire logic clk,
	input wire logic [15:0] readData,
	input wire logic readValid,
	output logic cmdRead,
	output logic cmdWrite,
	output logic [7:0] cmdCode,
	output logic [7:0] cmdData
);
	initial begin
		cmdRead = 1'h0;
		cmdWrite = 1'h0;
		cmdCode = 8'h00;
		cmdData = 8'h00;
	end
	// Read waits a bounded number of cycles for the answer
	task automatic rd(input logic [7:0] code, output logic [15:0] val, output bit ok);
		ok = 1'b0;
		val = 16'h0000;
		@(negedge clk);
		cmdCode = code;
		cmdRead = 1'h1;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			cmdRead = 1'h0;
			if (!ok && readValid === 1'b1) begin
				val = readData;
				ok = 1'b1;
			end
		end
		cmdCode = ~code;
	endtask
	task automatic wr1c(input logic [7:0] code, input logic [7:0] ones);
		@(negedge clk);
		cmdCode = code;
		cmdData = ones;
		cmdWrite = 1'h1;
		@(negedge clk);
		cmdWrite = 1'h0;
		cmdData = ~ones;
	endtask
endmodule

// >>> dv/pmbus_fault_status_bank_bench.sv
`timescale 1ns/1ps
`include "pfs_regs.svh"
module pmbus_fault_status_bank_bench;
	logic clk, rst, clearAllFaults, faultLogClear, cmdRead, cmdWrite, readValid, alertOut_n, alertOe, page;
	logic [15:0] voutEvt, ioutEvt, tempEvt, padInputs, readData, got;
	logic [7:0] inputEvt, cmlEvt, makerEvt, statusByteIn, commonInputs, cmdCode, cmdData;
	logic [1:0] gpPulledLowEvt, powerGood;
	int errors, comparisons;
	bit ok;
	pfs_host_model host (.clk(clk), .readData(readData), .readValid(readValid), .cmdRead(cmdRead),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData));
	pfs_fault_status_bank #(.CHANNELS(2)) uut (.clk(clk), .rst(rst), .vEvt0(2'h0), .voutEvt(voutEvt),
		.ioutEvt(ioutEvt), .inputEvt(inputEvt), .tempEvt(tempEvt), .cmlEvt(cmlEvt), .makerEvt(makerEvt),
		.gpPulledLowEvt(gpPulledLowEvt), .powerGood(powerGood), .statusByteIn(statusByteIn), .page(page),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData), .clearAllFaults(clearAllFaults),
		.faultLogClear(faultLogClear), .maskWrite(1'h0), .maskSel(3'h0), .maskData(8'h00), .cmdRead(cmdRead),
		.padInputs(padInputs), .commonInputs(commonInputs), .readData(readData), .readValid(readValid),
		.alertOut_n(alertOut_n), .alertOe(alertOe));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdchk(input string what, input logic [7:0] code, input logic [15:0] exp);
		host.rd(code, got, ok);
		if (!ok) begin
			errors++;
			$display("BAD %s expected answer seen none", what);
			close_out();
		end
		chk(what, exp, got);
	endtask
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask
	task automatic alert_is(input logic exp);
		chk("alertOe", {15'h0000, exp}, {15'h0000, alertOe});
		chk("alertOut_n", 16'h0000, {15'h0000, alertOut_n});
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_vout();
		@(negedge clk);
		voutEvt = 16'h0081;
		@(negedge clk);
		voutEvt = 16'h0000;
		settle();
		rdchk("vout", `PFS_CMD_VOUT, 16'h0080);
		rdchk("summary", `PFS_CMD_SUMMARY_WORD, 16'h805A);
		alert_is(1'b1);
		host.wr1c(`PFS_CMD_VOUT, 8'hFF);
		settle();
		rdchk("vout", `PFS_CMD_VOUT, 16'h0000);
		alert_is(1'b0);
		$display("test vout done");
	endtask
	task automatic t_input();
		@(negedge clk);
		inputEvt = 8'hFF;
		@(negedge clk);
		inputEvt = 8'h00;
		settle();
		rdchk("input", `PFS_CMD_INPUT, 16'h00AA);
		host.wr1c(`PFS_CMD_INPUT, 8'hFF);
		settle();
		rdchk("input", `PFS_CMD_INPUT, 16'h002A);
		alert_is(1'b0);
		$display("test input done");
	endtask
	task automatic t_clear_all();
		@(negedge clk);
		ioutEvt = 16'h00FF;
		tempEvt = 16'h00FF;
		cmlEvt = 8'hFF;
		@(negedge clk);
		ioutEvt = 16'h0000;
		tempEvt = 16'h0000;
		cmlEvt = 8'h00;
		settle();
		rdchk("iout", `PFS_CMD_IOUT, 16'h00A0);
		rdchk("temp", `PFS_CMD_TEMP, 16'h00D0);
		rdchk("cml", `PFS_CMD_CML, 16'h00FB);
		alert_is(1'b1);
		@(negedge clk);
		clearAllFaults = 1'h1;
		@(negedge clk);
		clearAllFaults = 1'h0;
		settle();
		rdchk("iout", `PFS_CMD_IOUT, 16'h0000);
		rdchk("input", `PFS_CMD_INPUT, 16'h0000);
		alert_is(1'b0);
		$display("test clear all done");
	endtask
	task automatic t_maker();
		@(negedge clk);
		makerEvt = 8'h10;
		gpPulledLowEvt = 2'h1;
		@(negedge clk);
		makerEvt = 8'h00;
		gpPulledLowEvt = 2'h0;
		settle();
		rdchk("maker", `PFS_CMD_MAKER, 16'h0011);
		alert_is(1'b0);
		@(negedge clk);
		makerEvt = 8'h08;
		@(negedge clk);
		makerEvt = 8'h00;
		settle();
		alert_is(1'b1);
		rdchk("summary", `PFS_CMD_SUMMARY_WORD, 16'h105A);
		host.wr1c(`PFS_CMD_MAKER, 8'hFF);
		settle();
		rdchk("maker", `PFS_CMD_MAKER, 16'h0008);
		@(negedge clk);
		faultLogClear = 1'h1;
		@(negedge clk);
		faultLogClear = 1'h0;
		settle();
		rdchk("maker", `PFS_CMD_MAKER, 16'h0000);
		$display("test maker done");
	endtask
	task automatic t_page();
		@(negedge clk);
		page = 1'h1;
		voutEvt = 16'h4000;
		gpPulledLowEvt = 2'h2;
		@(negedge clk);
		voutEvt = 16'h0000;
		gpPulledLowEvt = 2'h0;
		settle();
		rdchk("vout ch1", `PFS_CMD_VOUT, 16'h0040);
		rdchk("maker ch1", `PFS_CMD_MAKER, 16'h0001);
		page = 1'h0;
		rdchk("maker ch0", `PFS_CMD_MAKER, 16'h0000);
		page = 1'h1;
		alert_is(1'b1);
		host.wr1c(`PFS_CMD_VOUT, 8'h40);
		host.wr1c(`PFS_CMD_MAKER, 8'h01);
		settle();
		rdchk("vout ch1", `PFS_CMD_VOUT, 16'h0000);
		rdchk("maker ch1", `PFS_CMD_MAKER, 16'h0000);
		alert_is(1'b0);
		page = 1'h0;
		$display("test page done");
	endtask
	task automatic t_levels();
		@(negedge clk);
		powerGood = 2'h2;
		padInputs = 16'hFFFF;
		commonInputs = 8'hFF;
		settle();
		rdchk("summary", `PFS_CMD_SUMMARY_WORD, 16'h085A);
		rdchk("pads", `PFS_CMD_PADS, 16'hCFFF);
		host.wr1c(`PFS_CMD_PADS, 8'hFF);
		rdchk("pads", `PFS_CMD_PADS, 16'hCFFF);
		rdchk("common", `PFS_CMD_COMMON, 16'h00FB);
		$display("test levels done");
	endtask
	initial begin
		{voutEvt, ioutEvt, tempEvt, inputEvt, cmlEvt, makerEvt} = '0;
		{clearAllFaults, faultLogClear, gpPulledLowEvt, padInputs, commonInputs} = '0;
		powerGood = 2'h3;
		page = 1'h0;
		statusByteIn = 8'h5A;
		errors = 0;
		comparisons = 0;
		rst = 1'h1;
		repeat (20) @(negedge clk);
		rst = 1'h0;
		alert_is(1'b0);
		t_vout();
		t_input();
		t_clear_all();
		t_maker();
		t_page();
		t_levels();
		close_out();
	end
endmodule
